// ===== rip_map.svh
// rip_map.svh: register offsets, field positions, reset values and cycle counts
// of the reset and interrupt priority unit. Definitions only; include by bare name.
`ifndef RIP_MAP_SVH
`define RIP_MAP_SVH
// register offsets on the plain register port
`define RIP_OFF_SETTINGS 8'h00
`define RIP_OFF_BOOT 8'h01
`define RIP_OFF_PROMOTE 8'h02
`define RIP_OFF_MAPPING 8'h03
`define RIP_OFF_WD_SERVICE 8'h04
`define RIP_OFF_CAUSE 8'h05
// system settings register fields, rate select in bits 1:0
`define RIP_SET_CONV_PU 7
`define RIP_SET_IRQ_EDGE 5
`define RIP_SET_OSC_WAIT 4
`define RIP_SET_CLK_WATCH 3
`define RIP_SET_RATE_LO 0
`define RIP_SET_WRITE_MASK 8'hFB
`define RIP_SET_ONCE_MASK 8'h33
`define RIP_SET_RESET 8'h10
// boot setup register: watchdog disable bit
`define RIP_BOOT_WD_DIS 2
// priority promote register fields, promote code in bits 3:0
`define RIP_PRO_BOOT_ROM 7
`define RIP_PRO_SPECIAL 6
`define RIP_PRO_MODE_A 5
`define RIP_PRO_IRVNE 4
`define RIP_PROMOTE_RESET 4'h6
`define RIP_MAPPING_RESET 8'h01
// watchdog service key values
`define RIP_WD_ARM 8'h55
`define RIP_WD_CLEAR 8'hAA
// reset vectors
`define RIP_VEC_HI_NORMAL 8'hFF
`define RIP_VEC_HI_SPECIAL 8'hBF
`define RIP_VEC_LO_PIN 8'hFE
`define RIP_VEC_LO_CLK 8'hFC
`define RIP_VEC_LO_WD 8'hFA
// timing counts in E clock cycles, prescaler width in bits, maskable source count
`define RIP_WD_PRESCALE_BITS 15
`define RIP_ONCE_WINDOW_CYC 7'h40
`define RIP_HOLD_CYC 3'h4
`define RIP_FETCH_CYC 2'h3
`define RIP_SRC_COUNT 15
`endif

// ===== rip_pkg.sv
// rip_pkg: types of the reset and interrupt priority unit.
// assumes rip_map.svh supplies all numeric constants.
package rip_pkg;
	typedef enum logic [1:0] {RIP_HOLD, RIP_FETCH, RIP_RUN} rip_state_e;
	typedef enum logic [1:0] {RIP_CAUSE_PIN, RIP_CAUSE_CLK, RIP_CAUSE_WD} rip_cause_e;
	typedef enum logic [1:0] {RIP_NMI_NONE, RIP_NMI_PIN, RIP_NMI_ILLEGAL, RIP_NMI_TRAP} rip_nmi_e;
endpackage

// ===== rip_top.sv
// rip_top: reset sequencer, vector select, watchdog and interrupt priority unit.
// assumes all inputs synchronous to I_CLK (the E clock); maskable requests arrive already
// gated by their local masks; peripherals take their reset states from O_PERIPH_RESET.
// Function
// - clock watch enable always accessible; when set a slow clock starts a reset
// - every reset clears the clock watch enable bit
// - watchdog counts E clock divided by two to the fifteenth, then rate scaled
// - rate select 00,01,10,11 scales by 1, 4, 16, 64
// - watchdog disable 0 lets timeout reset; 1 blocks timeout reset
// - vector by cause: FFFE pin, FFFC clock, FFFA watchdog; BF high in special
// - three fetch cycles after reset; CPU mask and stop-inhibit flags set
// - reset loads mapping register with 01
// - reset puts timer counter, compares, flags and masks in known states
// - reset selects fifth compare and clears its pin actions
// - reset clears periodic tick flag, its mask and rate bits
// - reset disables pulse counter and synchronous serial port
// - watchdog enable follows disable bit at reset; shortest timeout rate
// - reset puts asynchronous serial port in its fixed idle states
// - reset clears converter power-up; other converter settings undefined
// - reset loads promote code 0110 and level-sensitive external request
// - mode flags catch mode pins at reset release; special modes may rewrite
// - reset sets oscillator startup wait; programming controls left disabled
// - non-maskable order: pin, clock, watchdog, nmi pin, illegal op, trap
// - fixed maskable order of fifteen sources, external request first
// - promoted source goes to top, still obeys masks, vector unchanged
// - promote code written only while global mask flag is set
// - promote codes map to sources; reserved 0101 means external request
`include "rip_map.svh"
module rip_top #(
	parameter int WD_PRESCALE_BITS = `RIP_WD_PRESCALE_BITS,
	parameter logic [7:0] BOOT_SETUP_INIT = 8'h0C // arbitrary nonvolatile default
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_PIN_RESET,
	input wire logic I_CLOCK_SLOW,
	input wire logic I_MODE_PIN_A,
	input wire logic I_MODE_PIN_B,
	input wire logic I_I_FLAG,
	input wire logic I_NMI_PIN,
	input wire logic I_ILLEGAL_OP,
	input wire logic I_SW_TRAP,
	input wire logic [`RIP_SRC_COUNT-1:0] I_IRQ_REQ,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA,
	output logic O_PERIPH_RESET,
	output logic O_VEC_FETCH,
	output logic O_CCR_SET_MASKS,
	output logic [15:0] O_RESET_VECTOR,
	output logic [1:0] O_CAUSE,
	output logic [1:0] O_NMI_SEL,
	output logic O_INT_VALID,
	output logic [3:0] O_INT_SRC,
	output logic [7:0] O_SETTINGS,
	output logic [7:0] O_MAPPING,
	output logic O_SPECIAL_MODE,
	output logic O_MODE_A,
	output logic O_BOOT_ROM
);
	localparam int WDW = WD_PRESCALE_BITS + 6;

	function automatic logic [WDW-1:0] wd_limit(input logic [1:0] rate);
		logic [WDW-1:0] one;
		one = {{(WDW-1){1'b0}}, 1'b1};
		wd_limit = (one << (WD_PRESCALE_BITS + 2 * int'(rate))) - one;
	endfunction

	function automatic logic [15:0] vector_of(input rip_pkg::rip_cause_e c, input logic special);
		logic [7:0] lo;
		lo = `RIP_VEC_LO_PIN;
		unique case (c)
			rip_pkg::RIP_CAUSE_PIN: lo = `RIP_VEC_LO_PIN;
			rip_pkg::RIP_CAUSE_CLK: lo = `RIP_VEC_LO_CLK;
			rip_pkg::RIP_CAUSE_WD: lo = `RIP_VEC_LO_WD;
			default: lo = `RIP_VEC_LO_PIN;
		endcase
		vector_of = {special ? `RIP_VEC_HI_SPECIAL : `RIP_VEC_HI_NORMAL, lo};
	endfunction

	// source index follows the fixed order: 0 external request .. 14 asynchronous serial
	function automatic logic [3:0] promote_index(input logic [3:0] code);
		unique case (code)
			4'h0: promote_index = 4'hA;
			4'h1: promote_index = 4'hB;
			4'h2: promote_index = 4'hC;
			4'h3: promote_index = 4'hD;
			4'h4: promote_index = 4'hE;
			4'h5: promote_index = 4'h0;
			4'h6: promote_index = 4'h0;
			4'h7: promote_index = 4'h1;
			default: promote_index = code - 4'h6;
		endcase
	endfunction

	function automatic logic [3:0] first_set(input logic [`RIP_SRC_COUNT-1:0] req);
		first_set = 4'h0;
		for (int k = `RIP_SRC_COUNT - 1; k >= 0; k--) begin
			if (req[k])
				first_set = 4'(k);
		end
	endfunction

	rip_pkg::rip_state_e state, next_state;
	rip_pkg::rip_cause_e cause, next_cause;
	logic [2:0] hold_cnt;
	logic [1:0] fetch_cnt;
	logic [7:0] settings;
	logic [7:0] boot;
	logic [7:0] mapping;
	logic [3:0] promote;
	logic special_mode_flag, mode_a_latch, boot_rom_enable, irvne;
	logic wd_dis_eff;
	logic once_done;
	logic [6:0] win_cnt;
	logic [WDW-1:0] wd_cnt;
	logic wd_armed;
	logic periph_rst, vec_fetch, int_valid;
	logic [3:0] int_src;
	rip_pkg::rip_nmi_e nmi_sel;
	logic [15:0] vector;
	logic [7:0] rdata;

	// decode and selection
	wire sys_rst = (state == rip_pkg::RIP_HOLD);
	wire clk_req = settings[`RIP_SET_CLK_WATCH] & I_CLOCK_SLOW;
	wire wd_timeout = (wd_cnt == wd_limit(settings[`RIP_SET_RATE_LO +: 2]));
	wire wd_req = wd_timeout & ~wd_dis_eff;
	wire any_req = I_PIN_RESET | clk_req | wd_req;
	wire release_now = sys_rst & ~any_req & (hold_cnt == `RIP_HOLD_CYC - 3'h1);
	wire wr_ok = I_WR & ~sys_rst;
	wire wr_set = wr_ok & (I_ADDR == `RIP_OFF_SETTINGS);
	wire wr_boot = wr_ok & (I_ADDR == `RIP_OFF_BOOT);
	wire wr_pro = wr_ok & (I_ADDR == `RIP_OFF_PROMOTE);
	wire wr_map = wr_ok & (I_ADDR == `RIP_OFF_MAPPING);
	wire wr_svc = wr_ok & (I_ADDR == `RIP_OFF_WD_SERVICE);
	// protected settings bits are write-once early after reset, free in special modes
	wire once_open = special_mode_flag | (~once_done & (win_cnt < `RIP_ONCE_WINDOW_CYC));
	wire [7:0] set_mask = once_open ? `RIP_SET_WRITE_MASK : (`RIP_SET_WRITE_MASK & ~`RIP_SET_ONCE_MASK);
	wire [7:0] next_settings = (settings & ~set_mask) | (I_WDATA & set_mask);
	wire [3:0] promo_idx = promote_index(promote);
	wire promo_hit = I_IRQ_REQ[promo_idx];
	wire [3:0] next_int_src = promo_hit ? promo_idx : first_set(I_IRQ_REQ);
	wire next_int_valid = (state == rip_pkg::RIP_RUN) & ~I_I_FLAG & (|I_IRQ_REQ);
	wire [7:0] pro_read = {boot_rom_enable, special_mode_flag, mode_a_latch, irvne, promote};
	wire [7:0] read_mux =
		(I_ADDR == `RIP_OFF_SETTINGS) ? settings :
		(I_ADDR == `RIP_OFF_BOOT) ? boot :
		(I_ADDR == `RIP_OFF_PROMOTE) ? pro_read :
		(I_ADDR == `RIP_OFF_MAPPING) ? mapping :
		(I_ADDR == `RIP_OFF_CAUSE) ? {6'h00, cause} : 8'h00;

	// reset cause priority: pin or power-on, then clock failure, then watchdog
	always_comb begin
		next_state = state;
		next_cause = cause;
		if (any_req) begin
			next_state = rip_pkg::RIP_HOLD;
			if (I_PIN_RESET)
				next_cause = rip_pkg::RIP_CAUSE_PIN;
			else if (clk_req)
				next_cause = rip_pkg::RIP_CAUSE_CLK;
			else
				next_cause = rip_pkg::RIP_CAUSE_WD;
		end else begin
			unique case (state)
				rip_pkg::RIP_HOLD: if (release_now) next_state = rip_pkg::RIP_FETCH;
				rip_pkg::RIP_FETCH: if (fetch_cnt == `RIP_FETCH_CYC - 2'h1) next_state = rip_pkg::RIP_RUN;
				rip_pkg::RIP_RUN: next_state = rip_pkg::RIP_RUN;
				default: next_state = rip_pkg::RIP_HOLD;
			endcase
		end
	end

	// sequencer; cause only changes on a new request, so it stands through the fetch
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			state <= rip_pkg::RIP_HOLD;
			cause <= rip_pkg::RIP_CAUSE_PIN;
			hold_cnt <= 3'h0;
			fetch_cnt <= 2'h0;
		end else begin
			state <= next_state;
			cause <= next_cause;
			hold_cnt <= (any_req || !sys_rst) ? 3'h0 : hold_cnt + 3'h1;
			fetch_cnt <= (state == rip_pkg::RIP_FETCH) ? fetch_cnt + 2'h1 : 2'h0;
		end
	end

	// sequencer outputs; peripherals hold their documented reset states while this is high
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			periph_rst <= 1'b1;
			vec_fetch <= 1'b0;
			vector <= {`RIP_VEC_HI_NORMAL, `RIP_VEC_LO_PIN};
		end else begin
			periph_rst <= (next_state == rip_pkg::RIP_HOLD);
			vec_fetch <= (next_state == rip_pkg::RIP_FETCH);
			vector <= vector_of(next_cause, release_now ? ~I_MODE_PIN_B : special_mode_flag);
		end
	end

	// system settings: reset clears converter power-up, clock watch and rate, sets startup wait
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			settings <= `RIP_SET_RESET;
			once_done <= 1'b0;
			win_cnt <= 7'h00;
		end else if (sys_rst) begin
			settings <= `RIP_SET_RESET;
			once_done <= 1'b0;
			win_cnt <= 7'h00;
		end else begin
			if (wr_set)
				settings <= next_settings;
			if (wr_set && !special_mode_flag)
				once_done <= 1'b1;
			if (win_cnt < `RIP_ONCE_WINDOW_CYC)
				win_cnt <= win_cnt + 7'h01;
		end
	end

	// boot setup is nonvolatile: a write only takes effect at the next reset
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST)
			boot <= BOOT_SETUP_INIT;
		else if (wr_boot)
			boot <= I_WDATA;
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST)
			mapping <= `RIP_MAPPING_RESET;
		else if (sys_rst)
			mapping <= `RIP_MAPPING_RESET;
		else if (wr_map)
			mapping <= I_WDATA;
	end

	// mode flags and watchdog enable are caught at the release edge of reset
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			special_mode_flag <= 1'b0;
			mode_a_latch <= 1'b0;
			boot_rom_enable <= 1'b0;
			irvne <= 1'b0;
			wd_dis_eff <= 1'b1;
			promote <= `RIP_PROMOTE_RESET;
		end else if (release_now) begin
			special_mode_flag <= ~I_MODE_PIN_B;
			mode_a_latch <= I_MODE_PIN_A;
			boot_rom_enable <= ~I_MODE_PIN_B & ~I_MODE_PIN_A;
			irvne <= ~I_MODE_PIN_B & I_MODE_PIN_A;
			wd_dis_eff <= boot[`RIP_BOOT_WD_DIS];
			promote <= `RIP_PROMOTE_RESET;
		end else if (sys_rst) begin
			promote <= `RIP_PROMOTE_RESET;
		end else if (wr_pro) begin
			if (I_I_FLAG)
				promote <= I_WDATA[3:0];
			irvne <= I_WDATA[`RIP_PRO_IRVNE];
			if (special_mode_flag) begin
				special_mode_flag <= I_WDATA[`RIP_PRO_SPECIAL];
				mode_a_latch <= I_WDATA[`RIP_PRO_MODE_A];
				boot_rom_enable <= I_WDATA[`RIP_PRO_BOOT_ROM];
			end
		end
	end

	// watchdog: one counter covers prescaler and rate stage; service is arm then clear
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			wd_cnt <= '0;
			wd_armed <= 1'b0;
		end else if (sys_rst) begin
			wd_cnt <= '0;
			wd_armed <= 1'b0;
		end else begin
			if (wr_svc && I_WDATA == `RIP_WD_CLEAR && wd_armed)
				wd_cnt <= '0;
			else if (wd_timeout)
				wd_cnt <= '0;
			else
				wd_cnt <= wd_cnt + {{(WDW-1){1'b0}}, 1'b1};
			if (wr_svc)
				wd_armed <= (I_WDATA == `RIP_WD_ARM);
		end
	end

	// interrupt selection, registered; nothing is offered until the sequencer reaches RIP_RUN
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			int_valid <= 1'b0;
			int_src <= 4'h0;
			nmi_sel <= rip_pkg::RIP_NMI_NONE;
		end else begin
			int_valid <= next_int_valid;
			int_src <= next_int_src;
			if (state != rip_pkg::RIP_RUN)
				nmi_sel <= rip_pkg::RIP_NMI_NONE;
			else if (I_NMI_PIN)
				nmi_sel <= rip_pkg::RIP_NMI_PIN;
			else if (I_ILLEGAL_OP)
				nmi_sel <= rip_pkg::RIP_NMI_ILLEGAL;
			else if (I_SW_TRAP)
				nmi_sel <= rip_pkg::RIP_NMI_TRAP;
			else
				nmi_sel <= rip_pkg::RIP_NMI_NONE;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST)
			rdata <= 8'h00;
		else
			rdata <= I_RD ? read_mux : 8'h00;
	end

	assign O_RDATA = rdata;
	assign O_PERIPH_RESET = periph_rst;
	assign O_VEC_FETCH = vec_fetch;
	assign O_CCR_SET_MASKS = vec_fetch;
	assign O_RESET_VECTOR = vector;
	assign O_CAUSE = cause;
	assign O_NMI_SEL = nmi_sel;
	assign O_INT_VALID = int_valid;
	assign O_INT_SRC = int_src;
	assign O_SETTINGS = settings;
	assign O_MAPPING = mapping;
	assign O_SPECIAL_MODE = special_mode_flag;
	assign O_MODE_A = mode_a_latch;
	assign O_BOOT_ROM = boot_rom_enable;

	default clocking dc @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	sequence s_fetch_three;
		O_VEC_FETCH [*3] ##1 !O_VEC_FETCH;
	endsequence

	a_clock_watch_reset: assert property (
		(state == rip_pkg::RIP_RUN && clk_req && !I_PIN_RESET) |=> O_PERIPH_RESET && cause == rip_pkg::RIP_CAUSE_CLK)
		else $error("clock watch did not start a reset");
	a_watch_cleared: assert property (
		sys_rst |=> !settings[`RIP_SET_CLK_WATCH] && settings[`RIP_SET_RATE_LO +: 2] == 2'h0)
		else $error("reset left clock watch or rate set");
	a_wd_limit_hit: assert property (
		(wd_cnt == wd_limit(settings[`RIP_SET_RATE_LO +: 2]) && state == rip_pkg::RIP_RUN) |=> wd_cnt == '0)
		else $error("watchdog counter did not wrap at its limit");
	a_wd_reset_on: assert property (
		(state == rip_pkg::RIP_RUN && wd_timeout && !wd_dis_eff && !I_PIN_RESET && !clk_req)
		|=> O_PERIPH_RESET && cause == rip_pkg::RIP_CAUSE_WD)
		else $error("watchdog timeout did not reset");
	a_wd_reset_off: assert property (
		(state == rip_pkg::RIP_RUN && wd_timeout && wd_dis_eff && !I_PIN_RESET && !clk_req) |=> !O_PERIPH_RESET)
		else $error("disabled watchdog forced a reset");
	a_vector_cause: assert property (
		O_VEC_FETCH |-> O_RESET_VECTOR == vector_of(cause, special_mode_flag))
		else $error("reset vector does not match cause and mode");
	a_fetch_three: assert property (
		disable iff (I_RST || I_PIN_RESET || clk_req) $rose(O_VEC_FETCH) |-> s_fetch_three)
		else $error("vector fetch not three cycles");
	a_mapping_reset: assert property (
		sys_rst |=> O_MAPPING == `RIP_MAPPING_RESET)
		else $error("mapping register not reloaded by reset");
	a_settings_reset: assert property (
		sys_rst |=> settings[`RIP_SET_OSC_WAIT] && !settings[`RIP_SET_CONV_PU] && !settings[`RIP_SET_IRQ_EDGE])
		else $error("settings reset state wrong");
	a_mode_catch: assert property (
		release_now |=> O_SPECIAL_MODE == !$past(I_MODE_PIN_B) && O_MODE_A == $past(I_MODE_PIN_A))
		else $error("mode flags not caught at reset release");
	a_promote_lock: assert property (
		(wr_pro && !I_I_FLAG && !release_now) |=> $stable(promote))
		else $error("promote code written while unmasked");
	a_promote_top: assert property (
		(state == rip_pkg::RIP_RUN && !I_I_FLAG && promo_hit) |=> O_INT_VALID && O_INT_SRC == $past(promo_idx))
		else $error("promoted source not on top");
	a_global_mask: assert property (
		I_I_FLAG |=> !O_INT_VALID)
		else $error("interrupt offered while masked");
	a_nmi_order: assert property (
		(state == rip_pkg::RIP_RUN && I_NMI_PIN) |=> O_NMI_SEL == rip_pkg::RIP_NMI_PIN)
		else $error("nonmaskable pin request lost priority");
endmodule

// ===== rip_cpu_model.sv
// rip_cpu_model: cpu core side that takes reset vectors and holds the global mask flag.
// assumes the unit's fetch strobe and vector are registered outputs on the same clock.
module rip_cpu_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_vec_fetch,
	input wire logic i_set_masks,
	input wire logic [15:0] i_vector,
	input wire logic i_mask_wr,
	input wire logic i_mask_val,
	output logic o_i_flag,
	output logic o_done,
	output logic [15:0] o_vec,
	output logic [2:0] o_len
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] cnt;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= 3'h0;
			o_done <= 1'b0;
			o_vec <= 16'h0000;
			o_len <= 3'h0;
			o_i_flag <= 1'b1;
		end else begin
			o_done <= 1'b0;
			// reset entry masks interrupts before software can touch the flag
			if (i_set_masks) begin
				o_i_flag <= 1'b1;
			end else if (i_mask_wr) begin
				o_i_flag <= i_mask_val;
			end
			if (i_vec_fetch) begin
				cnt <= cnt + 3'h1;
				o_vec <= i_vector;
			end else if (cnt != 3'h0) begin
				o_done <= 1'b1;
				o_len <= cnt;
				cnt <= 3'h0;
			end
		end
	end
endmodule

// ===== rip_top_bench.sv
// rip_top_bench: self-checking bench for the reset and interrupt priority unit.
// assumes rip_top and rip_cpu_model are compiled first; watchdog prescale cut to 4 bits.
`include "rip_map.svh"
module rip_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, pin_rst, slow, mode_a, mode_b, i_flag, nmi, ill, trap, wr, rd, mask_wr, mask_val, rd_q;
	logic [14:0] irq;
	logic [7:0] addr, wdata, rdata, settings, mapping;
	logic periph_rst, vec_fetch, set_masks, int_valid, special, mode_a_o, done, boot_rom;
	logic [15:0] vector, fvec;
	logic [1:0] cause, nmi_sel;
	logic [3:0] int_src;
	logic [2:0] flen;
	logic [15:0] rq[$];
	logic [15:0] vq[$];
	int error_cnt = 0;
	int compares = 0;
	int ndone = 0;
	logic [31:0] seed = 32'h0000_000D;
	rip_top #(.WD_PRESCALE_BITS(4)) dut_u (.I_CLK(clk), .I_RST(rst), .I_PIN_RESET(pin_rst),
		.I_CLOCK_SLOW(slow), .I_MODE_PIN_A(mode_a), .I_MODE_PIN_B(mode_b), .I_I_FLAG(i_flag),
		.I_NMI_PIN(nmi), .I_ILLEGAL_OP(ill), .I_SW_TRAP(trap), .I_IRQ_REQ(irq), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_PERIPH_RESET(periph_rst),
		.O_VEC_FETCH(vec_fetch), .O_CCR_SET_MASKS(set_masks), .O_RESET_VECTOR(vector), .O_CAUSE(cause),
		.O_NMI_SEL(nmi_sel), .O_INT_VALID(int_valid), .O_INT_SRC(int_src), .O_SETTINGS(settings),
		.O_MAPPING(mapping), .O_SPECIAL_MODE(special), .O_MODE_A(mode_a_o), .O_BOOT_ROM(boot_rom));
	rip_cpu_model cpu_u (.i_clk(clk), .i_rst(rst), .i_vec_fetch(vec_fetch), .i_set_masks(set_masks),
		.i_vector(vector), .i_mask_wr(mask_wr), .i_mask_val(mask_val), .o_i_flag(i_flag), .o_done(done),
		.o_vec(fvec), .o_len(flen));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// promote code to request index, reserved code falls back to the external request
	function automatic logic [3:0] pidx(input logic [3:0] c);
		case (c)
			4'h0, 4'h1, 4'h2, 4'h3, 4'h4: return c + 4'hA;
			4'h5, 4'h6: return 4'h0;
			4'h7: return 4'h1;
			default: return c - 4'h6;
		endcase
	endfunction
	// results land one cycle after their cause, so they are taken mid-cycle
	always @(posedge clk) rd_q <= rd;
	always @(negedge clk) begin
		logic [15:0] e;
		if (rd_q && rq.size() > 0) begin
			e = rq.pop_front();
			chk("read data", {8'h00, e[7:0]}, {8'h00, rdata & e[15:8]});
		end
		if (done) begin
			ndone++;
			if (vq.size() == 0) begin
				chk("unexpected reset", 16'h0000, 16'h0001);
			end else begin
				chk("reset vector", vq.pop_front(), fvec);
				chk("fetch length", 16'h0003, {13'h0000, flen});
			end
		end
	end
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		rq.push_back({m, e & m});
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic setmask(input logic v);
		@(posedge clk);
		mask_wr <= 1'b1;
		mask_val <= v;
		@(posedge clk);
		mask_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic vwait(input logic [15:0] v, output int cyc);
		int n;
		n = ndone + 1;
		vq.push_back(v);
		cyc = 0;
		while (ndone < n && cyc < 400) begin
			@(posedge clk);
			cyc++;
		end
		if (ndone < n) chk("fetch wait", 16'h0000, 16'h0001);
	endtask
	task automatic preset(input logic [15:0] v);
		int c;
		@(posedge clk);
		pin_rst <= 1'b1;
		@(posedge clk);
		pin_rst <= 1'b0;
		vwait(v, c);
	endtask
	initial begin
		#(20000 * 5);
		error_cnt++;
		finish_test();
	end
	initial begin
		int c;
		logic [3:0] e;
		logic [14:0] r;
		{rst, pin_rst, slow, mode_a, nmi, ill, trap, wr, rd, mask_wr, mask_val} = 11'h400;
		mode_b = 1'b1;
		irq = 15'h0000;
		addr = 8'h00;
		wdata = 8'h00;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		vwait(16'hFFFE, c);
		chk("settings output", 16'h0010, {8'h00, settings});
		chk("mapping output", 16'h0001, {8'h00, mapping});
		rreg(`RIP_OFF_SETTINGS, 8'hFF, 8'h10);
		rreg(`RIP_OFF_MAPPING, 8'hFF, 8'h01);
		rreg(`RIP_OFF_PROMOTE, 8'h0F, 8'h06);
		rreg(8'h80, 8'hFF, 8'h00);
		wreg(`RIP_OFF_PROMOTE, 8'h07);
		setmask(1'b0);
		wreg(`RIP_OFF_PROMOTE, 8'h03);
		rreg(`RIP_OFF_PROMOTE, 8'h0F, 8'h07);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			{nmi, ill, trap} <= k[2:0];
			@(posedge clk);
			@(negedge clk);
			chk("nonmaskable select", k[2] ? 16'h1 : k[1] ? 16'h2 : k[0] ? 16'h3 : 16'h0, {14'h0, nmi_sel});
		end
		{nmi, ill, trap} <= 3'h0;
		for (int p = 0; p < 16; p++) begin
			setmask(1'b1);
			wreg(`RIP_OFF_PROMOTE, {4'h0, p[3:0]});
			setmask(1'b0);
			repeat (4) begin
				r = 15'(xs() & xs());
				@(posedge clk);
				irq <= r;
				@(posedge clk);
				@(negedge clk);
				e = 4'h0;
				for (int k = 14; k >= 0; k--) if (r[k]) e = k[3:0];
				if (r[pidx(p[3:0])]) e = pidx(p[3:0]);
				chk("int valid", {15'h0, r != 15'h0}, {15'h0, int_valid});
				if (r != 15'h0) chk("int source", {12'h0, e}, {12'h0, int_src});
			end
		end
		setmask(1'b1);
		@(negedge clk);
		chk("masked int valid", 16'h0000, {15'h0, int_valid});
		@(posedge clk);
		irq <= 15'h0000;
		slow <= 1'b1;
		@(posedge clk);
		slow <= 1'b0;
		@(negedge clk);
		chk("watch off reset", 16'h0000, {15'h0, periph_rst});
		repeat (10) @(posedge clk);
		wreg(`RIP_OFF_SETTINGS, 8'h18);
		rreg(`RIP_OFF_SETTINGS, 8'hFF, 8'h18);
		slow <= 1'b1;
		@(posedge clk);
		slow <= 1'b0;
		vwait(16'hFFFC, c);
		chk("cause", 16'h0001, {14'h0, cause});
		rreg(`RIP_OFF_SETTINGS, 8'hFF, 8'h10);
		wreg(`RIP_OFF_MAPPING, 8'h35);
		rreg(`RIP_OFF_MAPPING, 8'hFF, 8'h35);
		wreg(`RIP_OFF_BOOT, 8'h08);
		preset(16'hFFFE);
		chk("mapping after reset", 16'h0001, {8'h00, mapping});
		wreg(`RIP_OFF_SETTINGS, 8'h11);
		vwait(16'hFFFA, c);
		chk("rate four span", 16'h0001, 16'(c >= 40 && c <= 110));
		chk("cause", 16'h0002, {14'h0, cause});
		vwait(16'hFFFA, c);
		chk("shortest span", 16'h0001, 16'(c <= 45));
		// arm then clear restarts the count, so this timeout comes a service later
		wreg(`RIP_OFF_WD_SERVICE, `RIP_WD_ARM);
		wreg(`RIP_OFF_WD_SERVICE, `RIP_WD_CLEAR);
		vwait(16'hFFFA, c);
		chk("serviced span", 16'h0001, 16'(c >= 22 && c <= 30));
		wreg(`RIP_OFF_BOOT, 8'h0C);
		preset(16'hFFFE);
		repeat (150) @(posedge clk);
		chk("watchdog off reset", 16'h0000, {15'h0, periph_rst});
		mode_b <= 1'b0;
		mode_a <= 1'b1;
		preset(16'hBFFE);
		chk("special mode", 16'h0001, {15'h0, special});
		chk("mode a", 16'h0001, {15'h0, mode_a_o});
		chk("test boot rom", 16'h0000, {15'h0, boot_rom});
		wreg(`RIP_OFF_PROMOTE, 8'h26);
		@(negedge clk);
		chk("special mode write", 16'h0000, {15'h0, special});
		@(posedge clk);
		mode_a <= 1'b0;
		preset(16'hBFFE);
		chk("bootstrap boot rom", 16'h0001, {15'h0, boot_rom});
		chk("bootstrap mode a", 16'h0000, {15'h0, mode_a_o});
		mode_b <= 1'b1;
		preset(16'hFFFE);
		chk("normal boot rom", 16'h0000, {15'h0, boot_rom});
		finish_test();
	end
endmodule
